// File: hw/rpm_top.sv
`timescale 1ns/1ps
module rpm_top (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // reference pulses and general inputs
  input  wire logic        ref_pulse,
  input  wire logic [6:0]  gen_input,
  // weighted pulse count and general outputs
  output logic             cnt_strobe,
  output logic      [6:0]  cnt_weight,
  output logic      [2:0]  gen_output,
  output logic             mult_active_n
);
  // stored software values
  logic [15:0]          enable_r;
  logic [15:0]          factor_r;
  logic [15:0]          sel_rt_r;
  logic [15:0]          out_rt_r;
  logic [15:0]          realloc_r;
  // applied configuration, then bus handshake, select and output state
  rpm_pkg::rpm_boot_cfg_t boot_r;
  logic                 wait_r;
  logic [31:0]          rdata_r;
  logic                 sel_nxt;
  logic                 act_r;
  logic                 strobe_r;
  logic [6:0]           weight_r;
  logic [2:0]           gout_r;
  logic                 act_n_r;
  logic                 req;
  logic                 done;
  logic                 wr_done;
  logic [3:0]           inv_idx;

  assign req     = read | write;
  assign done    = req & ~wait_r;
  assign wr_done = done & write;
  assign inv_idx = boot_r.sel_code - rpm_pkg::SEL_INV_BASE;

  assign readdata      = rdata_r;
  assign waitrequest   = wait_r;
  assign cnt_strobe    = strobe_r;
  assign cnt_weight    = weight_r;
  assign gen_output    = gout_r;
  assign mult_active_n = act_n_r;

  // one wait cycle, then the answer
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
    end else if (req && wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  // bus answers exactly one cycle after taking a request
  wait_one_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    !wait_r |=> wait_r)
    else $error("waitrequest low two cycles");

  wait_answer_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (req && wait_r) |=> !wait_r)
    else $error("request not answered");

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (read && wait_r) begin
      unique case (address)
        rpm_pkg::OFS_ENABLE:  rdata_r <= {16'h0000, enable_r};
        rpm_pkg::OFS_FACTOR:  rdata_r <= {16'h0000, factor_r};
        rpm_pkg::OFS_SEL_RT:  rdata_r <= {16'h0000, sel_rt_r};
        rpm_pkg::OFS_OUT_RT:  rdata_r <= {16'h0000, out_rt_r};
        rpm_pkg::OFS_REALLOC: rdata_r <= {16'h0000, realloc_r};
        rpm_pkg::OFS_STATUS:  rdata_r <= {28'h0000000, act_r, sel_nxt,
                                          boot_r.realloc, boot_r.enable};
        default:              rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  read_factor_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (read && wait_r && address == rpm_pkg::OFS_FACTOR)
    |=> readdata == {16'h0000, $past(factor_r)})
    else $error("factor readback wrong");

  // register writes take effect at the completing edge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      enable_r  <= rpm_pkg::RST_ENABLE;
      sel_rt_r  <= rpm_pkg::RST_SEL_RT;
      out_rt_r  <= rpm_pkg::RST_OUT_RT;
      realloc_r <= rpm_pkg::RST_REALLOC;
    end else if (wr_done) begin
      if (address == rpm_pkg::OFS_ENABLE) begin
        enable_r <= writedata[15:0];
      end
      if (address == rpm_pkg::OFS_SEL_RT) begin
        sel_rt_r <= writedata[15:0];
      end
      if (address == rpm_pkg::OFS_OUT_RT) begin
        out_rt_r <= writedata[15:0];
      end
      if (address == rpm_pkg::OFS_REALLOC) begin
        realloc_r <= writedata[15:0];
      end
    end
  end

  enable_write_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (wr_done && address == rpm_pkg::OFS_ENABLE)
    |=> enable_r == $past(writedata[15:0]))
    else $error("enable write lost");

  // factor is live; out-of-range writes are dropped
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      factor_r <= rpm_pkg::RST_FACTOR;
    end else if (wr_done && address == rpm_pkg::OFS_FACTOR &&
                 writedata[15:0] >= rpm_pkg::FACTOR_MIN &&
                 writedata[15:0] <= rpm_pkg::FACTOR_MAX &&
                 writedata[31:16] == 16'h0000) begin
      factor_r <= writedata[15:0];
    end
  end

  factor_range_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    factor_r >= rpm_pkg::FACTOR_MIN && factor_r <= rpm_pkg::FACTOR_MAX)
    else $error("factor out of range");

  factor_live_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (wr_done && address == rpm_pkg::OFS_FACTOR && writedata == 32'h0000_0005)
    |=> factor_r == 16'h0005)
    else $error("factor write not applied");

  factor_reject_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (wr_done && address == rpm_pkg::OFS_FACTOR && writedata[15:0] > rpm_pkg::FACTOR_MAX)
    |=> $stable(factor_r))
    else $error("out-of-range factor accepted");

  // a write to the power-cycle register reloads boot settings
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      boot_r <= rpm_pkg::BOOT_RST;
    end else if (wr_done && address == rpm_pkg::OFS_PWRCYC) begin
      boot_r.enable   <= (enable_r == 16'h0001);
      boot_r.sel_code <= sel_rt_r[3:0];
      boot_r.out_code <= out_rt_r[rpm_pkg::OUT_LSB +: 4];
      boot_r.realloc  <= (realloc_r[3:0] == rpm_pkg::REALLOC_ON);
    end
  end

  // applied settings move only on a power cycle
  enable_boot_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (rst_n && !(wr_done && address == rpm_pkg::OFS_PWRCYC)) |=> $stable(boot_r))
    else $error("boot config changed without power cycle");

  boot_enable_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (rst_n && wr_done && address == rpm_pkg::OFS_PWRCYC)
    |=> boot_r.enable == ($past(enable_r) == 16'h0001))
    else $error("enable not applied on power cycle");

  boot_route_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (rst_n && wr_done && address == rpm_pkg::OFS_PWRCYC)
    |=> boot_r.out_code == $past(out_rt_r[rpm_pkg::OUT_LSB +: 4]))
    else $error("output routing not applied on power cycle");

  // select decode
  always_comb begin
    sel_nxt = 1'b0;
    if (boot_r.realloc) begin
      if (boot_r.sel_code < rpm_pkg::SEL_FORCE_ON) begin
        sel_nxt = gen_input[boot_r.sel_code[2:0]];
      end else if (boot_r.sel_code == rpm_pkg::SEL_FORCE_ON) begin
        sel_nxt = 1'b1;
      end else if (boot_r.sel_code == rpm_pkg::SEL_FORCE_OFF) begin
        sel_nxt = 1'b0;
      end else begin
        sel_nxt = ~gen_input[inv_idx[2:0]];
      end
    end
  end

  force_on_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (boot_r.realloc && boot_r.sel_code == rpm_pkg::SEL_FORCE_ON) |-> sel_nxt)
    else $error("forced-on select not high");

  force_off_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (boot_r.realloc && boot_r.sel_code == rpm_pkg::SEL_FORCE_OFF) |-> !sel_nxt)
    else $error("forced-off select not low");

  direct_sel_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (boot_r.realloc && boot_r.sel_code == 4'h0) |-> sel_nxt == gen_input[0])
    else $error("direct select wrong");

  invert_sel_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (boot_r.realloc && boot_r.sel_code == rpm_pkg::SEL_INV_BASE) |-> sel_nxt == !gen_input[0])
    else $error("inverted select wrong");

  no_realloc_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    !boot_r.realloc |-> !sel_nxt)
    else $error("select without realloc");

  // switch only between pulses
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      act_r <= 1'b0;
    end else if (!ref_pulse) begin
      act_r <= sel_nxt & boot_r.enable;
    end
  end

  pulse_hold_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (rst_n && ref_pulse) |=> $stable(act_r))
    else $error("switched during pulse");

  disabled_one_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (!boot_r.enable ##1 !boot_r.enable) |=> weight_r == 7'h01)
    else $error("weight not one while disabled");

  // weighted pulse out
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      strobe_r <= 1'b0;
      weight_r <= 7'h01;
    end else begin
      strobe_r <= ref_pulse;
      weight_r <= act_r ? factor_r[6:0] : 7'h01;
    end
  end

  weight_fac_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (rst_n && act_r) |=> weight_r == $past(factor_r[6:0]))
    else $error("weight not factor");

  weight_one_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (rst_n && !act_r) |=> weight_r == 7'h01)
    else $error("weight not one");

  strobe_follow_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (rst_n && ref_pulse) |=> cnt_strobe)
    else $error("pulse not counted");

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      act_n_r <= 1'b1;
    end else begin
      act_n_r <= ~act_r;
    end
  end

  act_n_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (rst_n && act_r) |=> !mult_active_n)
    else $error("active flag not asserted");

  idle_n_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (rst_n && !act_r) |=> mult_active_n)
    else $error("active flag not released");

  // active-low status onto the routed output
  genvar gi;
  generate
    for (gi = 0; gi < rpm_pkg::NUM_OUT; gi++) begin : g_out
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          gout_r[gi] <= 1'b1;
        end else begin
          gout_r[gi] <= (boot_r.out_code == 4'(gi + 1)) ? ~act_r : 1'b1;
        end
      end
    end
  endgenerate

  out_follow_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (rst_n && boot_r.out_code == 4'h2 ##1 boot_r.out_code == 4'h2)
    |-> gen_output[1] == !$past(act_r) && gen_output[0] && gen_output[2])
    else $error("active output misrouted");

  out_off_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (boot_r.out_code == rpm_pkg::OUT_RT_OFF) |=> gen_output == 3'h7)
    else $error("output driven while disabled");
endmodule

// File: pkg/rpm_pkg.sv
package rpm_pkg;
  localparam logic [4:0]  OFS_ENABLE   = 5'h00;
  localparam logic [4:0]  OFS_FACTOR   = 5'h04;
  localparam logic [4:0]  OFS_SEL_RT   = 5'h08;
  localparam logic [4:0]  OFS_OUT_RT   = 5'h0c;
  localparam logic [4:0]  OFS_REALLOC  = 5'h10;
  localparam logic [4:0]  OFS_PWRCYC   = 5'h14;
  localparam logic [4:0]  OFS_STATUS   = 5'h18;
  localparam logic [15:0] RST_ENABLE   = 16'h0000;
  localparam logic [15:0] RST_FACTOR   = 16'h0001;
  localparam logic [15:0] RST_SEL_RT   = 16'h0008;
  localparam logic [15:0] RST_OUT_RT   = 16'h0000;
  localparam logic [15:0] RST_REALLOC  = 16'h0000;
  localparam logic [15:0] FACTOR_MIN   = 16'h0001;
  localparam logic [15:0] FACTOR_MAX   = 16'h0063;
  localparam logic [3:0]  SEL_FORCE_ON  = 4'h7;
  localparam logic [3:0]  SEL_FORCE_OFF = 4'h8;
  localparam logic [3:0]  SEL_INV_BASE  = 4'h9;
  localparam logic [3:0]  REALLOC_ON    = 4'h1;
  localparam logic [3:0]  OUT_RT_OFF    = 4'h0;
  localparam int          OUT_LSB       = 8;
  localparam int          NUM_IN        = 7;
  localparam int          NUM_OUT       = 3;

  // configuration latched at power-up
  typedef struct packed {
    logic       enable;
    logic [3:0] sel_code;
    logic [3:0] out_code;
    logic       realloc;
  } rpm_boot_cfg_t;

  localparam rpm_boot_cfg_t BOOT_RST = '{enable: 1'b0, sel_code: 4'h8,
                                         out_code: 4'h0, realloc: 1'b0};
endpackage

// File: sim/ref_pulse_multiplier_select_tb.sv
`timescale 1ns/1ps
module ref_pulse_multiplier_select_tb;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        ref_pulse;
  logic [6:0]  gen_input;
  logic        cnt_strobe;
  logic [6:0]  cnt_weight;
  logic [2:0]  gen_output;
  logic        mult_active_n;
  logic        pulse_req = 1'b0;
  logic [6:0]  sel_req = 7'h00;
  logic [31:0] q;
  logic [3:0]  code;
  logic [6:0]  gin;
  logic        act;
  int          errors = 0;
  int          comparisons = 0;
  // rows: select code, general inputs, expected active
  logic [11:0] rows [16] = '{12'h003, 12'h1fa, 12'h209, 12'h3ee, 12'h421, 12'h541, 12'h67e,
    12'h701, 12'h8fe, 12'h902, 12'ha01, 12'hbf7, 12'hc10, 12'hddf, 12'he40, 12'hf01};

  always #25 core_clk = ~core_clk;

  rpm_ctrl_model ctrl (.core_clk(core_clk), .pulse_req(pulse_req), .sel_req(sel_req),
    .ref_pulse(ref_pulse), .gen_input(gen_input));
  rpm_top dut (.core_clk(core_clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .ref_pulse(ref_pulse), .gen_input(gen_input), .cnt_strobe(cnt_strobe),
    .cnt_weight(cnt_weight), .gen_output(gen_output), .mult_active_n(mult_active_n));

  task automatic results;
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= d;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic pulse(input logic [6:0] w);
    pulse_req <= 1'b1;
    @(posedge core_clk);
    pulse_req <= 1'b0;
    for (int i = 0; i < 4 && cnt_strobe !== 1'b1; i++) @(posedge core_clk);
    chk("cnt_strobe", {31'h0, cnt_strobe}, 32'h1);
    chk("cnt_weight", {25'h0, cnt_weight}, {25'h0, w});
  endtask
  task automatic pwr;
    bus(1'b1, rpm_pkg::OFS_PWRCYC, 32'h0);
    sel_req <= gin;
    repeat (4) @(posedge core_clk);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    results();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rdc("enable", rpm_pkg::OFS_ENABLE, 32'h0);
    rdc("sel_rt", rpm_pkg::OFS_SEL_RT, 32'h8);
    rdc("out_rt", rpm_pkg::OFS_OUT_RT, 32'h0);
    rdc("realloc", rpm_pkg::OFS_REALLOC, 32'h0);
    rdc("unmapped", 5'h1c, 32'h0);
    bus(1'b1, rpm_pkg::OFS_FACTOR, 32'h0);
    bus(1'b1, rpm_pkg::OFS_FACTOR, 32'h64);
    rdc("factor", rpm_pkg::OFS_FACTOR, 32'h1);
    bus(1'b1, rpm_pkg::OFS_FACTOR, 32'h63);
    rdc("factor", rpm_pkg::OFS_FACTOR, 32'h63);
    bus(1'b1, rpm_pkg::OFS_ENABLE, 32'h1);
    bus(1'b1, rpm_pkg::OFS_REALLOC, 32'h1);
    bus(1'b1, rpm_pkg::OFS_OUT_RT, 32'h200);
    bus(1'b1, rpm_pkg::OFS_SEL_RT, 32'h7);
    rdc("pre_cycle", rpm_pkg::OFS_STATUS, 32'h0);
    for (int i = 0; i < 16; i++) begin
      {code, gin, act} = rows[i];
      bus(1'b1, rpm_pkg::OFS_SEL_RT, {28'h0, code});
      pwr();
      chk("active_n", {31'h0, mult_active_n}, {31'h0, ~act});
      chk("gen_out", {29'h0, gen_output}, {29'h0, 1'b1, ~act, 1'b1});
      pulse(act ? 7'h63 : 7'h01);
    end
    rdc("status", rpm_pkg::OFS_STATUS, 32'hf);
    bus(1'b1, rpm_pkg::OFS_FACTOR, 32'h5);
    pulse(7'h05);
    bus(1'b1, rpm_pkg::OFS_OUT_RT, 32'h300);
    chk("out_hold", {29'h0, gen_output}, 32'h5);
    pwr();
    chk("out_moved", {29'h0, gen_output}, 32'h3);
    bus(1'b1, rpm_pkg::OFS_OUT_RT, 32'h100);
    pwr();
    chk("out_one", {29'h0, gen_output}, 32'h6);
    bus(1'b1, rpm_pkg::OFS_ENABLE, 32'h0);
    pulse(7'h05);
    bus(1'b1, rpm_pkg::OFS_REALLOC, 32'h0);
    pwr();
    chk("no_realloc", {31'h0, mult_active_n}, 32'h1);
    chk("out_idle", {29'h0, gen_output}, 32'h7);
    rdc("status_off", rpm_pkg::OFS_STATUS, 32'h0);
    pulse(7'h01);
    rst_n <= 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rdc("factor", rpm_pkg::OFS_FACTOR, 32'h1);
    chk("gen_out", {29'h0, gen_output}, 32'h7);
    results();
  end
endmodule

// File: sim/rpm_ctrl_model.sv
`timescale 1ns/1ps
module rpm_ctrl_model (
  // clock
  input  wire logic       core_clk,
  // requests from the bench
  input  wire logic       pulse_req,
  input  wire logic [6:0] sel_req,
  // towards the device
  output logic            ref_pulse,
  output logic      [6:0] gen_input
);
  // select moves only while the pulse line is idle
  initial begin
    ref_pulse = 1'b0;
    gen_input = 7'h00;
    forever begin
      @(posedge core_clk);
      ref_pulse <= pulse_req;
      if (!pulse_req && !ref_pulse) begin
        gen_input <= sel_req;
      end
    end
  end
endmodule
